// *** rwc_core_model.sv ***
// core-side model: watchdog restart instructions and interrupt vector entry
module rwc_core_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // scenario control
   input wire logic kick_en,
   input wire logic ack_en,
   // block side
   input wire logic wdog_irq,
   output logic wdog_restart,
   output logic wdog_irq_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] cnt_q; // restart spacing, 1024 cycles, shorter than any timeout

   // periodic restart and vector entry, one-cycle pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 10'h000;
         wdog_restart <= 1'b0;
         wdog_irq_ack <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 10'h001;
         wdog_restart <= kick_en && cnt_q == 10'h3FF;
         wdog_irq_ack <= ack_en && wdog_irq && !wdog_irq_ack;
      end
   end
endmodule

// *** rwc_pkg.sv ***
// types shared by the reset/watchdog block
package rwc_pkg;

   // reset sequencer states
   typedef enum logic [1:0] {
      RWC_ST_HOLD,
      RWC_ST_WDPULSE,
      RWC_ST_STRETCH,
      RWC_ST_RUN
   } rwc_state_t;

   // register decode result
   typedef enum logic [1:0] {
      RWC_SEL_CAUSE,
      RWC_SEL_WDCTRL,
      RWC_SEL_NONE
   } rwc_sel_t;

endpackage

// *** rwc_regs.svh ***
// register map, field positions, reset values and timing counts of the reset/watchdog block
`ifndef RWC_REGS_SVH
`define RWC_REGS_SVH

// bus geometry
`define RWC_ADDR_W 12
`define RWC_DATA_W 32

// register byte offsets
`define RWC_CAUSE_OFS 12'h000
`define RWC_WDCTRL_OFS 12'h004

// reset cause fields
`define RWC_CAUSE_POR_BIT 0
`define RWC_CAUSE_PIN_BIT 1
`define RWC_CAUSE_BOD_BIT 2
`define RWC_CAUSE_WD_BIT 3
`define RWC_CAUSE_W 4
`define RWC_CAUSE_RST 4'h1
`define RWC_CAUSE_POR_VAL 4'h1

// watchdog control fields
`define RWC_WDC_IRQF_BIT 7
`define RWC_WDC_IRQE_BIT 6
`define RWC_WDC_WDP3_BIT 5
`define RWC_WDC_CE_BIT 4
`define RWC_WDC_RE_BIT 3
`define RWC_WDC_WDP_HI 2
`define RWC_WDC_WDP_LO 0
`define RWC_WDP_W 4
`define RWC_WDP_RST 4'h0

// timing
`define RWC_CLK_HZ 50000000
`define RWC_CLK_NS 20
`define RWC_WDOG_OSC_HZ 128000
`define RWC_WDOG_DIV_CYC (`RWC_CLK_HZ / `RWC_WDOG_OSC_HZ)
`define RWC_DIV_W 9
`define RWC_BOD_MIN_NS 2000
`define RWC_BOD_MIN_CYC ((`RWC_BOD_MIN_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS)
`define RWC_BOD_W 8
`define RWC_CE_WINDOW_CYC 4
`define RWC_CE_W 3
`define RWC_WDOG_BASE_TICKS 2048
`define RWC_WDOG_MAX_SEL 9
`define RWC_DELAY_BASE_CYC 64
`define RWC_BOD_OFF_CODE 3'h7

`endif

// *** rwc_top.sv ***
// reset sequencer, reset-cause flags and watchdog control with an APB register slave
`include "rwc_regs.svh"

module rwc_top #(
   parameter int unsigned WDOG_BASE_TICKS = `RWC_WDOG_BASE_TICKS,
   parameter int unsigned DELAY_BASE_CYC = `RWC_DELAY_BASE_CYC,
   parameter int unsigned DELAY_W = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RWC_ADDR_W-1:0] paddr,
   input wire logic [`RWC_DATA_W-1:0] pwdata,
   output logic [`RWC_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset sources
   input wire logic por_low,
   input wire logic ext_reset_n,
   input wire logic brownout_low,
   // fuses
   input wire logic pin_reset_disable_fuse,
   input wire logic wdog_always_on_fuse,
   input wire logic [1:0] startup_time_fuse,
   input wire logic [3:0] clock_select_fuse,
   input wire logic [2:0] brownout_level_fuse,
   // core events
   input wire logic wdog_restart,
   input wire logic wdog_irq_ack,
   // reset and watchdog outputs
   output logic io_reset,
   output logic sys_reset,
   output logic fetch_start,
   output logic wdog_irq,
   output logic wdog_wake
);

   localparam int unsigned DIV_CYC = `RWC_WDOG_DIV_CYC;
   localparam int unsigned BOD_CYC = `RWC_BOD_MIN_CYC;
   localparam int unsigned CE_CYC = `RWC_CE_WINDOW_CYC;

   // apb state
   logic [`RWC_DATA_W-1:0] prdata_q; // read data captured in setup
   logic pready_q; // high for the single access cycle
   logic pslverr_q; // unmapped address marker
   // reset sequencing
   rwc_pkg::rwc_state_t state_q; // sequencer state
   rwc_pkg::rwc_state_t state_d; // sequencer next state
   logic [DELAY_W-1:0] dly_cnt_q; // start-up delay count
   logic [DELAY_W-1:0] dly_limit; // fuse-selected delay length
   logic [2:0] dly_shift; // fuse-derived scale
   logic sys_reset_q; // internal reset
   logic io_reset_q; // port reset
   logic fetch_start_q; // reset vector fetch pulse
   // sources
   logic pin_src; // pin low and not disabled
   logic hard_src; // sources that act without a clock
   logic hard_rst_n; // combined asynchronous reset
   logic bod_en; // detector enabled by fuses
   logic [`RWC_BOD_W-1:0] bod_cnt_q; // low-supply persistence count
   logic bod_valid_q; // brown-out accepted
   // cause flags
   logic [`RWC_CAUSE_W-1:0] cause_q; // reset cause flags
   logic [`RWC_CAUSE_W-1:0] cause_set; // hardware set events
   logic [`RWC_CAUSE_W-1:0] cause_clr; // software zero-writes
   // watchdog control
   logic irq_flag_q; // timeout interrupt flag
   logic irq_en_q; // interrupt enable as written
   logic re_q; // reset enable as written
   logic ce_q; // change window open
   logic [`RWC_CE_W-1:0] ce_cnt_q; // window age
   logic [`RWC_WDP_W-1:0] wdp_q; // timeout select
   logic ie_eff; // interrupt enable after fuse
   logic re_eff; // reset enable after fuse and flag
   logic irq_set; // timeout raises interrupt
   logic irq_clr; // vector or write-one clears flag
   logic wd_rst_req; // timeout raises reset
   logic wdog_irq_q; // interrupt request
   logic wdog_wake_q; // wake pulse
   // oscillator divider
   logic [`RWC_DIV_W-1:0] div_cnt_q; // divider count
   logic tick_q; // oscillator-rate enable
   // bus decode
   logic setup; // setup phase
   logic access; // completing access phase
   logic wr_en; // write takes effect
   rwc_pkg::rwc_sel_t sel; // decoded register
   logic wr_wdc; // write to watchdog control
   logic wr_cause; // write to cause flags
   logic [`RWC_DATA_W-1:0] rd_mux; // read data source
   logic w_ce; // written change enable
   logic w_re; // written reset enable
   logic w_ie; // written interrupt enable
   logic w_irqf; // written interrupt flag
   logic [`RWC_WDP_W-1:0] w_wdp; // written timeout select

   rwc_wdog_if wif ();

   // address decode, shared by read capture and write
   function automatic rwc_pkg::rwc_sel_t decode(input logic [`RWC_ADDR_W-1:0] a);
      if (a == `RWC_CAUSE_OFS) begin
         return rwc_pkg::RWC_SEL_CAUSE;
      end else if (a == `RWC_WDCTRL_OFS) begin
         return rwc_pkg::RWC_SEL_WDCTRL;
      end
      return rwc_pkg::RWC_SEL_NONE;
   endfunction

   // outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign io_reset = io_reset_q;
   assign sys_reset = sys_reset_q;
   assign fetch_start = fetch_start_q;
   assign wdog_irq = wdog_irq_q;
   assign wdog_wake = wdog_wake_q;

   // clockless sources: pin and power-on act through the async reset
   assign pin_src = ~ext_reset_n & ~pin_reset_disable_fuse;
   assign hard_src = por_low | pin_src;
   assign hard_rst_n = presetn & ~hard_src;

   // bus phase decode
   assign setup = psel & ~penable;
   assign access = psel & penable & pready_q;
   assign wr_en = access & pwrite;
   assign sel = decode(paddr);
   assign wr_wdc = wr_en && (sel == rwc_pkg::RWC_SEL_WDCTRL);
   assign wr_cause = wr_en && (sel == rwc_pkg::RWC_SEL_CAUSE);

   // write data fields
   assign w_irqf = pwdata[`RWC_WDC_IRQF_BIT];
   assign w_ie = pwdata[`RWC_WDC_IRQE_BIT];
   assign w_ce = pwdata[`RWC_WDC_CE_BIT];
   assign w_re = pwdata[`RWC_WDC_RE_BIT];
   assign w_wdp = {pwdata[`RWC_WDC_WDP3_BIT], pwdata[`RWC_WDC_WDP_HI:`RWC_WDC_WDP_LO]};

   // read mux; unused cause bits read zero
   always_comb begin
      rd_mux = '0;
      unique case (sel)
         rwc_pkg::RWC_SEL_CAUSE: begin
            rd_mux = {{(`RWC_DATA_W-`RWC_CAUSE_W){1'b0}}, cause_q};
         end
         rwc_pkg::RWC_SEL_WDCTRL: begin
            rd_mux = {24'h000000, irq_flag_q, ie_eff, wdp_q[3], ce_q, re_eff, wdp_q[2:0]};
         end
         rwc_pkg::RWC_SEL_NONE: begin
            rd_mux = '0;
         end
      endcase
   end

   // apb slave: no wait states, pready in the first access cycle, data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= setup;
         if (setup) begin
            pslverr_q <= (sel == rwc_pkg::RWC_SEL_NONE);
            prdata_q <= pwrite ? '0 : rd_mux;
         end else if (access) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // brown-out filter: low supply must persist past the minimum time
   assign bod_en = (brownout_level_fuse != `RWC_BOD_OFF_CODE);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bod_cnt_q <= '0;
         bod_valid_q <= 1'b0;
      end else if (!(bod_en && brownout_low)) begin
         bod_cnt_q <= '0; // recovery drops the source at once
         bod_valid_q <= 1'b0;
      end else if (bod_cnt_q == `RWC_BOD_W'(BOD_CYC)) begin
         bod_valid_q <= 1'b1;
      end else begin
         bod_cnt_q <= bod_cnt_q + `RWC_BOD_W'(1);
      end
   end

   // fuse-selected start-up delay length
   assign dly_shift = {1'b0, startup_time_fuse} + {2'b00, clock_select_fuse[0]};
   assign dly_limit = DELAY_W'(DELAY_BASE_CYC) << dly_shift;

   // sequencer next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         rwc_pkg::RWC_ST_HOLD: begin
            if (!bod_valid_q) begin
               state_d = rwc_pkg::RWC_ST_STRETCH;
            end
         end
         rwc_pkg::RWC_ST_WDPULSE: begin
            state_d = rwc_pkg::RWC_ST_STRETCH;
         end
         rwc_pkg::RWC_ST_STRETCH: begin
            if (bod_valid_q) begin
               state_d = rwc_pkg::RWC_ST_HOLD;
            end else if (dly_cnt_q == dly_limit - DELAY_W'(1)) begin
               state_d = rwc_pkg::RWC_ST_RUN;
            end
         end
         rwc_pkg::RWC_ST_RUN: begin
            if (bod_valid_q) begin
               state_d = rwc_pkg::RWC_ST_HOLD;
            end else if (wd_rst_req) begin
               state_d = rwc_pkg::RWC_ST_WDPULSE;
            end
         end
      endcase
   end

   // sequencer state; clockless sources force hold without an edge
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         state_q <= rwc_pkg::RWC_ST_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // delay counter runs only while stretching
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         dly_cnt_q <= '0;
      end else if (state_q == rwc_pkg::RWC_ST_STRETCH) begin
         dly_cnt_q <= dly_cnt_q + DELAY_W'(1);
      end else begin
         dly_cnt_q <= '0;
      end
   end

   // reset outputs; set asynchronously, released on the clock
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         sys_reset_q <= 1'b1;
         io_reset_q <= 1'b1;
         fetch_start_q <= 1'b0;
      end else begin
         sys_reset_q <= (state_d != rwc_pkg::RWC_ST_RUN);
         io_reset_q <= bod_valid_q || (state_d == rwc_pkg::RWC_ST_WDPULSE);
         fetch_start_q <= (state_q == rwc_pkg::RWC_ST_STRETCH) && (state_d == rwc_pkg::RWC_ST_RUN);
      end
   end

   // cause flag events; pin is sampled while it holds the reset
   assign cause_set = {wd_rst_req, bod_valid_q, pin_src, 1'b0};
   assign cause_clr = wr_cause ? ~pwdata[`RWC_CAUSE_W-1:0] : '0;

   // cause flags survive all but power-on; set wins over a zero-write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= `RWC_CAUSE_RST;
      end else if (por_low) begin
         cause_q <= `RWC_CAUSE_POR_VAL;
      end else begin
         cause_q <= (cause_q & ~cause_clr) | cause_set;
      end
   end

   // effective enables: fuse locks reset mode, cause flag pins reset enable
   assign ie_eff = irq_en_q & ~wdog_always_on_fuse;
   assign re_eff = re_q | cause_q[`RWC_CAUSE_WD_BIT] | wdog_always_on_fuse;

   // timeout outcome per mode; combined mode resets if flag still pending
   assign irq_set = wif.expire && ie_eff && (!re_eff || !irq_flag_q);
   assign wd_rst_req = wif.expire && re_eff && !(ie_eff && !irq_flag_q);
   assign irq_clr = wdog_irq_ack || (wr_wdc && w_irqf);

   // change window: opened only by change and reset enable in one write
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         ce_q <= 1'b0;
         ce_cnt_q <= '0;
      end else if (sys_reset_q) begin
         ce_q <= 1'b0;
         ce_cnt_q <= '0;
      end else if (wr_wdc && w_ce && w_re) begin
         ce_q <= 1'b1;
         ce_cnt_q <= '0;
      end else if (ce_q) begin
         if (ce_cnt_q == `RWC_CE_W'(CE_CYC - 1)) begin
            ce_q <= 1'b0;
         end else begin
            ce_cnt_q <= ce_cnt_q + `RWC_CE_W'(1);
         end
      end
   end

   // reset enable and timeout select; clearing or retiming needs the window
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         re_q <= 1'b0;
         wdp_q <= `RWC_WDP_RST;
      end else if (sys_reset_q) begin
         re_q <= 1'b0;
         wdp_q <= `RWC_WDP_RST;
      end else if (wr_wdc) begin
         if (ce_q && !w_ce) begin
            re_q <= w_re;
            wdp_q <= w_wdp;
         end else if (w_re) begin
            re_q <= 1'b1; // setting is never guarded
         end
      end
   end

   // interrupt enable; vector in combined mode drops to reset mode
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         irq_en_q <= 1'b0;
      end else if (sys_reset_q) begin
         irq_en_q <= 1'b0;
      end else if (wdog_irq_ack && re_eff) begin
         irq_en_q <= 1'b0;
      end else if (wr_wdc) begin
         irq_en_q <= w_ie;
      end
   end

   // interrupt flag; a timeout in the clearing cycle still sets it
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         irq_flag_q <= 1'b0;
      end else if (sys_reset_q) begin
         irq_flag_q <= 1'b0;
      end else begin
         irq_flag_q <= (irq_flag_q & ~irq_clr) | irq_set;
      end
   end

   // interrupt request and wake pulse
   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         wdog_irq_q <= 1'b0;
         wdog_wake_q <= 1'b0;
      end else begin
         wdog_irq_q <= irq_flag_q & ie_eff;
         wdog_wake_q <= irq_set;
      end
   end

   // oscillator-rate enable; keeps running through system reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (div_cnt_q == `RWC_DIV_W'(DIV_CYC - 1)) begin
         div_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + `RWC_DIV_W'(1);
         tick_q <= 1'b0;
      end
   end

   // timer hookup; stopped mode holds the count at zero
   assign wif.tick = tick_q;
   assign wif.restart = wdog_restart;
   assign wif.run = re_eff | ie_eff;
   assign wif.prescale = wdp_q;

   rwc_wdog_timer #(
      .BASE_TICKS(WDOG_BASE_TICKS)
   ) u_timer (
      .clk(pclk),
      .rst_n(presetn),
      .w(wif.timer)
   );

endmodule

// *** rwc_top_properties.sv ***
// concurrent checks on the ports of the reset/watchdog block
`include "rwc_regs.svh"

module rwc_top_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RWC_ADDR_W-1:0] paddr,
   input wire logic [`RWC_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sources and fuses
   input wire logic por_low,
   input wire logic ext_reset_n,
   input wire logic brownout_low,
   input wire logic pin_reset_disable_fuse,
   input wire logic wdog_always_on_fuse,
   input wire logic [2:0] brownout_level_fuse,
   // outputs
   input wire logic io_reset,
   input wire logic sys_reset,
   input wire logic fetch_start,
   input wire logic wdog_irq,
   input wire logic wdog_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [7:0] bod_q; // cycles of enabled low supply, saturating

   // length of the current brown-out indication
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         bod_q <= 8'h00;
      else if (brownout_low && brownout_level_fuse != `RWC_BOD_OFF_CODE)
         bod_q <= (bod_q == 8'hC8) ? bod_q : bod_q + 8'h01;
      else
         bod_q <= 8'h00;
   end

   chk_por_no_delay: assert property (por_low |-> io_reset && sys_reset)
      else $error("power-on low without reset");
   chk_pin_resets: assert property (!ext_reset_n && !pin_reset_disable_fuse |-> io_reset)
      else $error("pin low without reset");
   chk_stretch_min: assert property ($fell(io_reset) |-> sys_reset [*3])
      else $error("internal reset not stretched");
   chk_fetch_end: assert property ($fell(sys_reset) |-> fetch_start ##1 !fetch_start)
      else $error("fetch start missing at reset end");
   chk_bod_valid: assert property (bod_q == 8'h6E |-> io_reset && sys_reset)
      else $error("long brown-out without reset");
   chk_wake_pulse: assert property (wdog_wake |=> !wdog_wake && wdog_irq)
      else $error("wake pulse wrong");
   chk_ready_setup: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_cause_upper: assert property (pready && !pwrite && paddr == `RWC_CAUSE_OFS |-> prdata[31:4] == 28'h0)
      else $error("cause upper bits not zero");
   chk_fuse_lock: assert property (pready && !pwrite && paddr == `RWC_WDCTRL_OFS && wdog_always_on_fuse
      |-> prdata[3] && !prdata[6])
      else $error("always-on lock not shown");
endmodule

bind rwc_top rwc_top_properties rwc_top_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .por_low, .ext_reset_n, .brownout_low, .pin_reset_disable_fuse,
   .wdog_always_on_fuse, .brownout_level_fuse, .io_reset, .sys_reset, .fetch_start, .wdog_irq, .wdog_wake);

// *** rwc_wdog_if.sv ***
// link between the watchdog control logic and its timer
interface rwc_wdog_if;
   logic tick;            // oscillator-rate enable pulse
   logic restart;         // clear the count
   logic run;             // watchdog active
   logic [3:0] prescale;  // timeout select
   logic expire;          // one-cycle timeout pulse

   modport ctrl (output tick, output restart, output run, output prescale, input expire);
   modport timer (input tick, input restart, input run, input prescale, output expire);
endinterface

// *** rwc_wdog_timer.sv ***
// watchdog timeout counter driven by oscillator-rate ticks
`include "rwc_regs.svh"

module rwc_wdog_timer #(
   parameter int unsigned BASE_TICKS = `RWC_WDOG_BASE_TICKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control side
   rwc_wdog_if.timer w
);

   localparam int unsigned CNT_W = $clog2(BASE_TICKS) + `RWC_WDOG_MAX_SEL + 1;

   logic [CNT_W-1:0] cnt_q; // ticks since last restart

   // terminal count for a select code; codes past the longest clamp to it
   function automatic logic [CNT_W-1:0] term_count(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > 4'(`RWC_WDOG_MAX_SEL)) ? 4'(`RWC_WDOG_MAX_SEL) : sel;
      return (CNT_W'(BASE_TICKS) << s) - CNT_W'(1);
   endfunction

   // counting; >= so that shrinking the timeout mid-count still expires
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         w.expire <= 1'b0;
      end else begin
         w.expire <= 1'b0;
         if (w.restart || !w.run) begin
            cnt_q <= '0;
         end else if (w.tick) begin
            if (cnt_q >= term_count(w.prescale)) begin
               cnt_q <= '0;
               w.expire <= 1'b1;
            end else begin
               cnt_q <= cnt_q + CNT_W'(1);
            end
         end
      end
   end

endmodule

// *** tb_rwc_top.sv ***
// self-checking bench of the reset/watchdog block
`include "rwc_regs.svh"

module tb_rwc_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 4; // shortened stretch base
   localparam logic [11:0] CA = `RWC_CAUSE_OFS;
   localparam logic [11:0] WC = `RWC_WDCTRL_OFS;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, rn;
   logic por_low, ext_reset_n, brownout_low, pin_reset_disable_fuse, wdog_always_on_fuse;
   logic [1:0] startup_time_fuse;
   logic [3:0] clock_select_fuse;
   logic [2:0] brownout_level_fuse;
   logic wdog_restart, wdog_irq_ack, io_reset, sys_reset, fetch_start, wdog_irq, wdog_wake;
   logic kick_en, ack_en, er;
   int miscompares, num_checks, seed, n, i;

   rwc_top #(.WDOG_BASE_TICKS(4), .DELAY_BASE_CYC(DLY), .DELAY_W(20)) rwc_top_inst (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .por_low, .ext_reset_n,
      .brownout_low, .pin_reset_disable_fuse, .wdog_always_on_fuse, .startup_time_fuse,
      .clock_select_fuse, .brownout_level_fuse, .wdog_restart, .wdog_irq_ack, .io_reset, .sys_reset,
      .fetch_start, .wdog_irq, .wdog_wake);
   rwc_core_model rwc_core_model_inst (.pclk, .presetn, .kick_en, .ack_en, .wdog_irq, .wdog_restart,
      .wdog_irq_ack);

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // compare and count
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // one apb transfer, answer taken at the edge where pready is high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // a missing answer is a failure even on writes
      if (pready !== 1'b1) begin
         miscompares++;
      end
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read and compare
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask

   // bounded wait on sys_reset (s=0) or wdog_irq (s=1)
   task wt(input bit s, input logic v, input int lim);
      int k;
      k = 0;
      while ((s ? wdog_irq : sys_reset) !== v && k < lim) begin
         @(negedge pclk);
         k++;
      end
      chk({31'h0, s ? wdog_irq : sys_reset}, {31'h0, v});
   endtask

   // verdict, single exit
   task stop_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // hang guard, far beyond the expected run
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      stop_test;
   end

   initial begin
      seed = 32'h295178AB;
      {presetn, psel, penable, pwrite, paddr, pwdata, por_low, brownout_low} = '0;
      {pin_reset_disable_fuse, wdog_always_on_fuse, startup_time_fuse, clock_select_fuse} = '0;
      {kick_en, ack_en, miscompares, num_checks} = '0;
      ext_reset_n = 1'b1;
      brownout_level_fuse = `RWC_BOD_OFF_CODE;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (sys_reset === 1'b1 && n < 100);
      chk(n, DLY + 2);
      chk({31'h0, fetch_start}, 32'h1);
      rd(CA, 32'h1);
      rd(WC, 32'h0);
      apb(1'b1, CA, 32'h0);
      rd(CA, 32'h0);
      rd(12'h008, 32'h0);
      chk({31'h0, er}, 32'h1);
      // pin reset acts without waiting for an edge
      @(posedge pclk);
      ext_reset_n <= 1'b0;
      #1 chk({31'h0, io_reset}, 32'h1);
      repeat (3) @(posedge pclk);
      ext_reset_n <= 1'b1;
      wt(0, 1'b0, 200);
      rd(CA, 32'h2);
      pin_reset_disable_fuse <= 1'b1;
      ext_reset_n <= 1'b0;
      repeat (5) @(negedge pclk);
      chk({31'h0, io_reset}, 32'h0);
      @(posedge pclk);
      ext_reset_n <= 1'b1;
      // brown-out: random short dips are filtered, a long one resets
      brownout_level_fuse <= 3'h0;
      for (i = 0; i < 3; i++) begin
         @(posedge pclk);
         brownout_low <= 1'b1;
         repeat (1 + $unsigned($random(seed)) % 90) @(posedge pclk);
         brownout_low <= 1'b0;
         @(negedge pclk);
         chk({31'h0, io_reset}, 32'h0);
      end
      @(posedge pclk);
      brownout_low <= 1'b1;
      repeat (120) @(negedge pclk);
      chk({31'h0, io_reset}, 32'h1);
      @(posedge pclk);
      brownout_low <= 1'b0;
      wt(0, 1'b0, 200);
      rd(CA, 32'h6);
      rn = $random(seed);
      apb(1'b1, CA, rn);
      rd(CA, {28'h0, 4'h6 & rn[3:0]});
      // power-on drop clears the other causes
      por_low <= 1'b1;
      repeat (3) @(posedge pclk);
      por_low <= 1'b0;
      wt(0, 1'b0, 200);
      rd(CA, 32'h1);
      apb(1'b1, CA, 32'h0);
      // interrupt mode, vector entry clears the flag
      apb(1'b1, WC, 32'h40);
      wt(1, 1'b1, 3000);
      rd(WC, 32'hC0);
      ack_en <= 1'b1;
      repeat (4) @(negedge pclk);
      ack_en <= 1'b0;
      rd(WC, 32'h40);
      apb(1'b1, WC, 32'h0);
      // reset mode kept alive by restarts
      kick_en <= 1'b1;
      apb(1'b1, WC, 32'h08);
      repeat (3000) @(negedge pclk);
      rd(CA, 32'h0);
      // combined mode: interrupt first, then reset
      kick_en <= 1'b0;
      apb(1'b1, WC, 32'h48);
      wt(1, 1'b1, 3000);
      rd(WC, 32'hC8);
      wt(0, 1'b1, 3000);
      kick_en <= 1'b1;
      wt(0, 1'b0, 200);
      rd(CA, 32'h8);
      rd(WC, 32'h08);
      apb(1'b1, WC, 32'h18);
      apb(1'b1, WC, 32'h00);
      rd(WC, 32'h08);
      // timed change sequence and its window
      apb(1'b1, CA, 32'h0);
      apb(1'b1, WC, 32'h18);
      rd(WC, 32'h18);
      // the read above uses up the window, so open a fresh one
      apb(1'b1, WC, 32'h18);
      apb(1'b1, WC, 32'h01);
      rd(WC, 32'h01);
      apb(1'b1, WC, 32'h02);
      rd(WC, 32'h01);
      apb(1'b1, WC, 32'h18);
      repeat (6) @(posedge pclk);
      apb(1'b1, WC, 32'h03);
      rd(WC, 32'h09);
      apb(1'b1, WC, 32'h18);
      apb(1'b1, WC, 32'h00);
      rd(WC, 32'h00);
      // always-on fuse locks the enables
      wdog_always_on_fuse <= 1'b1;
      rd(WC, 32'h08);
      wdog_always_on_fuse <= 1'b0;
      stop_test;
   end
endmodule
